// file: hdl/flash_front.sv
`timescale 1ns/1ns
`include "flash_front_defs.svh"

// Function
// - Work in serial clock mode 0 and mode 3, which differ only in the clock idle level.
// - Every incoming command, address and data bit is sampled on the clock rising edge.
// - Every outgoing bit is launched from the clock falling edge.
// - In multi-line mode the four pins drive data lines 0 to 3 out; only line 0 is ever read as input.
// - The array is cut into uniform 4 Kbyte sectors and 32 Kbyte blocks.
// - A 32 Kbyte block is eight adjacent sectors on a 32 Kbyte aligned address.
// - Larger densities also group sixteen sectors into 64 Kbyte blocks.
// - Software reaches exactly two register sets, status and function.
// - Status holds lock, quad enable, four protect bits, write enable latch, busy; reset zero.
// - The status contents decide which array areas are protected from erase.
// - Busy reads one during an internal register write or erase cycle, else zero.
// - With quad enable set, protect and pause pins become data lines and lose their function.
module flash_front (
  // System
  input wire logic clk,
  input wire logic rstn,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic data_line_0_in,
  output logic data_line_0_out,
  output logic data_line_0_oe,
  input wire logic data_line_1_in,
  output logic data_line_1_out,
  output logic data_line_1_oe,
  input wire logic data_line_2_in,
  output logic data_line_2_out,
  output logic data_line_2_oe,
  input wire logic data_line_3_in,
  output logic data_line_3_out,
  output logic data_line_3_oe,
  // Erase requests to the array core
  output logic erase_valid,
  output flash_front_pkg::erase_kind_t erase_kind,
  output logic [23:0] erase_addr,
  output logic erase_blocked,
  input wire logic erase_done,
  // Register contents
  output logic [7:0] status,
  output logic [7:0] func_reg
);
  import flash_front_pkg::*;

  function automatic logic [5:0] cmd_len(input logic [7:0] op);
    case (op)
      OP_WRITE_ENABLE, OP_WRITE_DISABLE: cmd_len = `LEN_OPCODE;
      OP_WRITE_STATUS, OP_WRITE_FUNC: cmd_len = `LEN_WITH_BYTE;
      OP_ERASE_SECTOR, OP_ERASE_BLK32: cmd_len = `LEN_WITH_ADDR;
      OP_ERASE_BLK64: cmd_len = `HAS_BLOCK64 ? `LEN_WITH_ADDR : 6'h00;
      default: cmd_len = 6'h00;
    endcase
  endfunction

  function automatic logic is_erase(input logic [7:0] op);
    is_erase = (op == OP_ERASE_SECTOR) || (op == OP_ERASE_BLK32) ||
      ((op == OP_ERASE_BLK64) && `HAS_BLOCK64);
  endfunction

  // Top protect codes cover the highest 64 Kbyte blocks, doubling per step
  function automatic logic block_protected(input logic [2:0] blk, input logic [3:0] bp);
    logic [3:0] first;
    first = `BLOCK64_COUNT - (4'h1 << (bp - 4'h1));
    if (bp == 4'h0)
      block_protected = 1'b0;
    else if (bp >= 4'h4)
      block_protected = 1'b1;
    else
      block_protected = {1'b0, blk} >= first;
  endfunction

  // Link side: clocked by the master's serial clock only
  logic [7:0] status_sck;
  logic [7:0] func_sck;
  logic [5:0] cnt;
  logic [31:0] shift;
  logic [7:0] op_hold;
  logic done_seen;
  logic rd_single;
  logic rd_quad;
  logic rd_func;
  logic [3:0] tx;
  logic drv_single;
  logic drv_quad;
  logic [7:0] cmd_op;
  logic [23:0] cmd_arg;
  logic cmd_tgl;
  logic link_rst;

  wire qe_sck = status_sck[`SR_QE_BIT];
  wire hold_active = ~qe_sck & ~data_line_3_in;
  wire [5:0] next_cnt = (cnt == `CNT_LAST) ? `CNT_WRAP : cnt + 6'h01;
  wire [31:0] next_shift = {shift[30:0], data_line_0_in};
  wire op_done = (cnt == `LEN_OPCODE - 6'h01);
  wire [7:0] cur_op = op_done ? next_shift[7:0] : op_hold;
  wire frame_done = ~done_seen & (cmd_len(cur_op) == next_cnt);
  wire [7:0] rd_src = rd_func ? func_sck : status_sck;

  sync2 #(
    .WIDTH(16)
  ) u_sync_link (
    .clk(sck),
    .d({status, func_reg}),
    .q({status_sck, func_sck})
  );

  // Deselect clears the frame at once; mode 3 idles high so no stray edge counts
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      cnt <= 6'h00;
      shift <= 32'h0000_0000;
      op_hold <= 8'h00;
      done_seen <= 1'b0;
      rd_single <= 1'b0;
      rd_quad <= 1'b0;
      rd_func <= 1'b0;
    end
    else if (!hold_active)
    begin
      cnt <= next_cnt;
      shift <= next_shift;
      if (frame_done)
        done_seen <= 1'b1;
      if (op_done)
      begin
        op_hold <= next_shift[7:0];
        rd_single <= (next_shift[7:0] == OP_READ_STATUS) || (next_shift[7:0] == OP_READ_FUNC);
        rd_quad <= (next_shift[7:0] == OP_READ_STATUS_QUAD) && qe_sck;
        rd_func <= (next_shift[7:0] == OP_READ_FUNC);
      end
    end
  end

  // Command word stays put until the next frame, long after the other side reads it
  always_ff @(posedge sck or posedge link_rst)
  begin
    if (link_rst)
    begin
      cmd_op <= 8'h00;
      cmd_arg <= 24'h00_0000;
      cmd_tgl <= 1'b0;
    end
    else if (!cs_n && !hold_active && frame_done)
    begin
      cmd_op <= cur_op;
      cmd_arg <= next_shift[23:0];
      cmd_tgl <= ~cmd_tgl;
    end
  end

  // Output launched on the falling edge, read by the master on the next rise
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      tx <= 4'h0;
      drv_single <= 1'b0;
      drv_quad <= 1'b0;
    end
    else
    begin
      drv_single <= rd_single;
      drv_quad <= rd_quad;
      if (rd_quad)
        tx <= cnt[0] ? rd_src[3:0] : rd_src[7:4];
      else
        tx <= {3'h0, rd_src[~cnt[2:0]]};
    end
  end

  // Pause floats the serial output; in quad mode all four lines drive
  assign data_line_0_out = tx[0];
  assign data_line_0_oe = drv_quad;
  assign data_line_1_out = drv_quad ? tx[1] : tx[0];
  assign data_line_1_oe = (drv_single | drv_quad) & ~hold_active;
  assign data_line_2_out = tx[2];
  assign data_line_2_oe = drv_quad;
  assign data_line_3_out = tx[3];
  assign data_line_3_oe = drv_quad;

  // System side
  state_t state;
  state_t next_state;
  logic tgl_sync;
  logic wp_sync;
  logic tgl_prev;
  logic [11:0] timer;
  logic lock;
  logic qe;
  logic [3:0] bp;
  logic write_enable_latch;
  logic [7:0] next_func;
  logic wr_func;

  sync2 #(
    .WIDTH(2)
  ) u_sync_sys (
    .clk(clk),
    .d({cmd_tgl, data_line_2_in}),
    .q({tgl_sync, wp_sync})
  );

  wire cmd_event = tgl_sync ^ tgl_prev;
  wire busy = (state != ST_IDLE);
  wire ev_wren = cmd_event & (cmd_op == OP_WRITE_ENABLE) & ~busy;
  wire ev_wrdi = cmd_event & (cmd_op == OP_WRITE_DISABLE) & ~busy;
  // Protect pin only guards the locked register while quad mode is off
  wire reg_locked = lock & ~qe & ~wp_sync;
  wire ev_wrsr = cmd_event & (cmd_op == OP_WRITE_STATUS) & write_enable_latch & ~busy & ~reg_locked;
  wire ev_wrfr = cmd_event & (cmd_op == OP_WRITE_FUNC) & write_enable_latch & ~busy;
  wire ev_erase = cmd_event & is_erase(cmd_op) & write_enable_latch & ~busy;
  wire [2:0] blk64_idx = cmd_arg[`ADDR_MSB:`BLK64_LSB];
  wire [6:0] sector_idx = cmd_arg[`ADDR_MSB:`SECTOR_LSB];
  wire [3:0] blk32_idx = cmd_arg[`ADDR_MSB:`BLK32_LSB];
  wire area_protected = block_protected(blk64_idx, bp);
  wire erase_go = ev_erase & ~area_protected;
  wire erase_stop = ev_erase & area_protected;
  wire reg_write_end = (state == ST_REG_WRITE) && (timer == 12'h000);
  wire erase_end = (state == ST_ERASE) && erase_done;

  wire erase_kind_t ev_kind = (cmd_op == OP_ERASE_SECTOR) ? ERASE_SECTOR :
    (cmd_op == OP_ERASE_BLK32) ? ERASE_BLK32 : ERASE_BLK64;
  // Aligned start address of the unit that holds the given byte address
  wire [23:0] sector_base = {5'h00, sector_idx, 12'h000};
  wire [23:0] blk32_base = {5'h00, blk32_idx, 15'h0000};
  wire [23:0] blk64_base = {5'h00, blk64_idx, 16'h0000};
  wire [23:0] ev_base = (ev_kind == ERASE_SECTOR) ? sector_base :
    (ev_kind == ERASE_BLK32) ? blk32_base : blk64_base;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (ev_wrsr || ev_wrfr)
          next_state = ST_REG_WRITE;
        else if (erase_go)
          next_state = ST_ERASE;
      ST_REG_WRITE:
        if (reg_write_end)
          next_state = ST_IDLE;
      ST_ERASE:
        if (erase_end)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  assign wr_func = ev_wrfr;
  assign next_func = cmd_arg[7:0];

  always_ff @(posedge clk)
  begin
    link_rst <= ~rstn;
    tgl_prev <= rstn ? tgl_sync : 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      timer <= 12'h000;
    else if (ev_wrsr || ev_wrfr)
      timer <= 12'(`REG_WRITE_CYCLES - 1);
    else if (timer != 12'h000)
      timer <= timer - 12'h001;
  end

  // Write latch drops when a write cycle ends; a new enable cannot meet it while busy
  always_ff @(posedge clk)
  begin
    if (!rstn)
      write_enable_latch <= 1'(`SR_RESET >> `SR_WEL_BIT);
    else if (ev_wren)
      write_enable_latch <= 1'b1;
    else if (ev_wrdi || reg_write_end || erase_end)
      write_enable_latch <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      lock <= 1'(`SR_RESET >> `SR_LOCK_BIT);
      qe <= 1'(`SR_RESET >> `SR_QE_BIT);
      bp <= 4'(`SR_RESET >> `SR_BP_LO);
    end
    else if (ev_wrsr)
    begin
      lock <= cmd_arg[`SR_LOCK_BIT];
      qe <= cmd_arg[`SR_QE_BIT];
      bp <= cmd_arg[`SR_BP_HI:`SR_BP_LO];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      func_reg <= `FR_RESET;
    else if (wr_func)
      func_reg <= next_func;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      status <= `SR_RESET;
    else
      status <= {lock, qe, bp, write_enable_latch, busy};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      erase_valid <= 1'b0;
      erase_blocked <= 1'b0;
      erase_kind <= ERASE_SECTOR;
      erase_addr <= 24'h00_0000;
    end
    else
    begin
      erase_valid <= erase_go;
      erase_blocked <= erase_stop;
      if (erase_go)
      begin
        erase_kind <= ev_kind;
        erase_addr <= ev_base;
      end
    end
  end
endmodule // flash_front

// file: common/flash_front_defs.svh
`ifndef FLASH_FRONT_DEFS_SVH
`define FLASH_FRONT_DEFS_SVH

// Status register field positions and reset value
`define SR_LOCK_BIT 7
`define SR_QE_BIT 6
`define SR_BP_HI 5
`define SR_BP_LO 2
`define SR_WEL_BIT 1
`define SR_BUSY_BIT 0
`define SR_RESET 8'h00
`define FR_RESET 8'h00

// Frame lengths in link clock edges
`define LEN_OPCODE 6'h08
`define LEN_WITH_BYTE 6'h10
`define LEN_WITH_ADDR 6'h20
`define CNT_WRAP 6'h20
`define CNT_LAST 6'h3f

// Array map
`define ADDR_MSB 18
`define SECTOR_LSB 12
`define BLK32_LSB 15
`define BLK64_LSB 16
`define BLOCK64_COUNT 4'h8
`define HAS_BLOCK64 1'b1

// Timing
`define CLK_PERIOD_NS 10
`define REG_WRITE_NS 1000
`define REG_WRITE_CYCLES ((`REG_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: common/flash_front_pkg.sv
package flash_front_pkg;

  typedef enum logic [7:0] {
    OP_WRITE_STATUS = 8'h01,
    OP_WRITE_DISABLE = 8'h04,
    OP_READ_STATUS = 8'h05,
    OP_WRITE_ENABLE = 8'h06,
    OP_ERASE_SECTOR = 8'h20,
    OP_WRITE_FUNC = 8'h42,
    OP_READ_FUNC = 8'h48,
    OP_ERASE_BLK32 = 8'h52,
    OP_READ_STATUS_QUAD = 8'h75,
    OP_ERASE_BLK64 = 8'hd8
  } op_t;

  typedef enum logic [1:0] {
    ERASE_SECTOR = 2'h0,
    ERASE_BLK32 = 2'h1,
    ERASE_BLK64 = 2'h2
  } erase_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REG_WRITE = 3'b010,
    ST_ERASE = 3'b100
  } state_t;

endpackage

// file: hdl/sync2.sv
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input wire logic clk,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    meta <= d;
    q <= meta;
  end
endmodule // sync2

// file: bench/flash_front_props.sv
`timescale 1ns/1ns
module flash_front_props (
  // System
  input wire logic clk,
  input wire logic rstn,
  // Link
  input wire logic cs_n,
  input wire logic data_line_3_in,
  input wire logic data_line_0_oe,
  input wire logic data_line_1_oe,
  input wire logic data_line_2_oe,
  input wire logic data_line_3_oe,
  // Core side
  input wire logic erase_valid,
  input wire flash_front_pkg::erase_kind_t erase_kind,
  input wire logic [23:0] erase_addr,
  input wire logic erase_blocked,
  input wire logic erase_done,
  input wire logic [7:0] status
);
  import flash_front_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  oe_idle_a: assert property (cs_n |-> !(data_line_0_oe || data_line_1_oe
    || data_line_2_oe || data_line_3_oe)) else $error("output enable while deselected");
  pause_gate_a: assert property (!cs_n && !status[6] && !data_line_3_in
    |-> !data_line_1_oe) else $error("output driven while paused");
  sector_align_a: assert property (erase_valid && erase_kind == ERASE_SECTOR
    |-> erase_addr[11:0] == 12'h000) else $error("sector start not aligned");
  blk32_align_a: assert property (erase_valid && erase_kind == ERASE_BLK32
    |-> erase_addr[14:0] == 15'h0000) else $error("32K block start not aligned");
  blk64_align_a: assert property (erase_valid && erase_kind == ERASE_BLK64
    |-> erase_addr[15:0] == 16'h0000) else $error("64K block start not aligned");
  erase_busy_a: assert property (erase_valid |=> status[0] && !erase_valid)
    else $error("erase request without busy");
  blocked_kept_a: assert property (erase_blocked |-> !erase_valid ##1
    status[1] && !status[0]) else $error("refused erase changed status");
  done_clears_a: assert property (erase_done |-> ##[1:2] status[1:0] == 2'b00)
    else $error("busy or latch left after erase");
  busy_latch_a: assert property ($rose(status[0]) |-> $past(status[1]))
    else $error("busy without write enable");
  reset_zero_a: assert property (@(posedge clk) disable iff (1'b0)
    !rstn |=> status == 8'h00) else $error("status not cleared by reset");
endmodule // flash_front_props

bind flash_front flash_front_props flash_front_props_i (.clk(clk), .rstn(rstn),
  .cs_n(cs_n), .data_line_3_in(data_line_3_in), .data_line_0_oe(data_line_0_oe),
  .data_line_1_oe(data_line_1_oe), .data_line_2_oe(data_line_2_oe),
  .data_line_3_oe(data_line_3_oe), .erase_valid(erase_valid), .erase_kind(erase_kind),
  .erase_addr(erase_addr), .erase_blocked(erase_blocked), .erase_done(erase_done),
  .status(status));

// file: bench/spi_master.sv
`timescale 1ns/1ns
module spi_master (
  // Link
  output logic sck,
  output logic cs_n,
  output logic mosi,
  output logic wp_n,
  output logic hold_n,
  // Device answer
  input wire logic miso_out,
  input wire logic miso_oe
);
  // Released line reads unknown, never a stale level
  wire miso = miso_oe ? miso_out : 1'bx;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    wp_n = 1'b1;
    hold_n = 1'b1;
  end
  task automatic frame(input logic [39:0] bits, input int n, input logic m,
    output logic [7:0] rd);
    sck = m;
    #40;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sck = 1'b0;
      mosi = bits[39 - i];
      #80;
      if (i > 7)
        rd = {rd[6:0], miso};
      sck = 1'b1;
      #80;
    end
    sck = m;
    #40;
    cs_n = 1'b1;
    #160;
  endtask
endmodule // spi_master

// file: bench/test_flash_front.sv
`timescale 1ns/1ns
module test_flash_front;
  import flash_front_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic erase_done = 1'b0;
  logic sck, cs_n, d0, wp_n, hold_n, erase_valid, erase_blocked;
  logic d0_out, d0_oe, d1_out, d1_oe, d2_out, d2_oe, d3_out, d3_oe;
  erase_kind_t erase_kind;
  logic [23:0] erase_addr;
  logic [7:0] status, func_reg, rd;
  int error_cnt = 0;
  int checked = 0;
  int n_erase = 0;
  int n_block = 0;
  logic [7:0] ops [3] = '{OP_ERASE_SECTOR, OP_ERASE_BLK32, OP_ERASE_BLK64};
  logic [23:0] addrs [3] = '{24'h01_5678, 24'h02_9abc, 24'h03_ffff};
  logic [23:0] starts [3] = '{24'h01_5000, 24'h02_8000, 24'h03_0000};
  always #5 clk = ~clk;
  flash_front flash_front_i (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n),
    .data_line_0_in(d0), .data_line_0_out(d0_out), .data_line_0_oe(d0_oe),
    .data_line_1_in(1'b0), .data_line_1_out(d1_out), .data_line_1_oe(d1_oe),
    .data_line_2_in(wp_n), .data_line_2_out(d2_out), .data_line_2_oe(d2_oe),
    .data_line_3_in(hold_n), .data_line_3_out(d3_out), .data_line_3_oe(d3_oe),
    .erase_valid(erase_valid), .erase_kind(erase_kind), .erase_addr(erase_addr),
    .erase_blocked(erase_blocked), .erase_done(erase_done), .status(status),
    .func_reg(func_reg));
  spi_master spi_master_i (.sck(sck), .cs_n(cs_n), .mosi(d0), .wp_n(wp_n),
    .hold_n(hold_n), .miso_out(d1_out), .miso_oe(d1_oe));
  // Core answers late so busy is seen well after the frame ends
  always @(negedge clk)
    if (erase_valid === 1'b1)
    begin
      n_erase++;
      repeat (60) @(negedge clk);
      erase_done = 1'b1;
      @(negedge clk);
      erase_done = 1'b0;
    end
  always @(negedge clk)
    if (erase_blocked === 1'b1)
      n_block++;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d of %0d checks", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmd(input logic [39:0] bits, input int n, input logic m = 1'b0);
    spi_master_i.frame(bits, n, m, rd);
    repeat (8) @(negedge clk);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 3000 && status[0] !== 1'b0; i++)
      @(negedge clk);
    check(24'(status[0]), 24'h0);
    repeat (2) @(negedge clk);
  endtask
  initial
  begin
    #500_000;
    error_cnt++;
    give_verdict;
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    check(24'(status), 24'h00);
    check(24'(func_reg), 24'h00);
    cmd({OP_READ_STATUS, 32'h0}, 16);
    check(24'(rd), 24'h00);
    cmd({OP_WRITE_ENABLE, 32'h0}, 8);
    cmd({OP_READ_STATUS, 32'h0}, 16, 1'b1);
    check(24'(rd), 24'h02);
    cmd({OP_WRITE_STATUS, 8'h0e, 24'h0}, 16);
    check(24'(status[0]), 24'h1);
    wait_ready;
    check(24'(status), 24'h0c);
    cmd({OP_WRITE_ENABLE, 32'h0}, 8);
    cmd({OP_ERASE_SECTOR, 24'h04_0000, 8'h0}, 32);
    check(24'(n_block), 24'h1);
    check(24'(status), 24'h0e);
    for (int k = 0; k < 3; k++)
    begin
      cmd({OP_WRITE_ENABLE, 32'h0}, 8);
      cmd({ops[k], addrs[k], 8'h0}, 32);
      check(24'(n_erase), 24'(k + 1));
      check(24'(erase_kind), 24'(k));
      check(erase_addr, starts[k]);
      check(24'(status[0]), 24'h1);
      wait_ready;
      check(24'(status), 24'h0c);
    end
    cmd({OP_WRITE_ENABLE, 32'h0}, 8);
    cmd({OP_WRITE_FUNC, 8'h5a, 24'h0}, 16);
    wait_ready;
    check(24'(func_reg), 24'h5a);
    cmd({OP_READ_FUNC, 32'h0}, 16, 1'b1);
    check(24'(rd), 24'h5a);
    cmd({OP_WRITE_ENABLE, 32'h0}, 8);
    cmd({OP_WRITE_STATUS, 8'h40, 24'h0}, 16);
    wait_ready;
    cmd({OP_READ_STATUS, 32'h0}, 16);
    check(24'(rd), 24'h40);
    spi_master_i.hold_n = 1'b0;
    cmd({OP_READ_STATUS, 32'h0}, 16);
    check(24'(rd), 24'h40);
    spi_master_i.hold_n = 1'b1;
    cmd({OP_WRITE_ENABLE, 32'h0}, 8);
    cmd({OP_READ_STATUS_QUAD, 32'h0}, 16);
    check(24'(rd), 24'h55);
    rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    check(24'(status), 24'h00);
    cmd({OP_READ_STATUS, 32'h0}, 16);
    check(24'(rd), 24'h00);
    spi_master_i.hold_n = 1'b0;
    cmd({OP_WRITE_ENABLE, 32'h0}, 8);
    spi_master_i.hold_n = 1'b1;
    check(24'(status), 24'h00);
    cmd({OP_WRITE_ENABLE, 32'h0}, 8);
    cmd({OP_WRITE_STATUS, 8'h80, 24'h0}, 16);
    wait_ready;
    spi_master_i.wp_n = 1'b0;
    cmd({OP_WRITE_ENABLE, 32'h0}, 8);
    cmd({OP_WRITE_STATUS, 8'h00, 24'h0}, 16);
    check(24'(status), 24'h82);
    spi_master_i.wp_n = 1'b1;
    cmd({OP_WRITE_STATUS, 8'h00, 24'h0}, 16);
    wait_ready;
    check(24'(status), 24'h00);
    give_verdict;
  end
endmodule // test_flash_front
